// [logic/lbh_pkg.sv]
// Package for the local-bus hold arbiter: cycle status codes, states, timing.
// Assumes a single system clock; no software-visible registers.
package lbh_pkg;

	// Cycle status codes; bit 2 = memory, bit 1 = data transmitted
	localparam logic [2:0] LBH_ST_RSVD   = 3'h0;
	localparam logic [2:0] LBH_ST_IORD   = 3'h1;
	localparam logic [2:0] LBH_ST_IOWR   = 3'h2;
	localparam logic [2:0] LBH_ST_HALT   = 3'h3;
	localparam logic [2:0] LBH_ST_FETCH  = 3'h4;
	localparam logic [2:0] LBH_ST_MEMRD  = 3'h5;
	localparam logic [2:0] LBH_ST_MEMWR  = 3'h6;
	localparam logic [2:0] LBH_ST_PASV   = 3'h7;

	// Refresh cycles are shown as memory reads
	localparam logic [2:0] LBH_REFRESH_KIND = LBH_ST_MEMRD;

	// Worst-case hold latency: four bus cycles of four clocks each, no waits
	localparam int LBH_CLKS_PER_CYCLE = 4;
	localparam int LBH_MAX_HOLD_CYCLES = 4;
	localparam int LBH_MAX_HOLD_CLKS = LBH_CLKS_PER_CYCLE * LBH_MAX_HOLD_CYCLES;

	// Reset values
	localparam logic       LBH_ACK_RST    = 1'b0;
	localparam logic       LBH_RD_N_RST   = 1'b1;
	localparam logic       LBH_LOCK_RST   = 1'b0;
	localparam logic [2:0] LBH_SYNC_RST   = 3'h0;

	typedef enum logic [2:0]
	{
		LBH_IDLE    = 3'b000,
		LBH_T1      = 3'b001,
		LBH_T2      = 3'b010,
		LBH_T3      = 3'b011,
		LBH_T4      = 3'b100,
		LBH_HELD    = 3'b101,
		LBH_RECLAIM = 3'b110
	} lbh_state_e;

	function automatic logic lbh_is_read(input logic [2:0] kind);
		return (kind == LBH_ST_IORD) || (kind == LBH_ST_MEMRD) || (kind == LBH_ST_FETCH);
	endfunction

endpackage

// [logic/lbh_sync_if.sv]
// Carries the raw takeover request pin and its synchronised level.
// Assumes the raw side is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
interface lbh_sync_if;
	logic raw;
	logic level;
	modport sink (input raw, output level);
	modport user (output raw, input level);
endinterface
`default_nettype wire

// [logic/lbh_sync.sv]
// Three-flop input synchroniser with agreement filter.
// Assumes mclk free-running; the raw input may change at any time.
`timescale 1ns/1ps
`default_nettype none
module lbh_sync
	import lbh_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	lbh_sync_if.sink  sif
);
	logic [2:0] sh_q;
	logic       level_q;

	// First stage feeds only the second; a level counts once stages 2 and 3 agree
	always_ff @(posedge mclk)
	begin
		if (rst)
			sh_q <= LBH_SYNC_RST;
		else
			sh_q <= {sh_q[1:0], sif.raw};
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			level_q <= 1'b0;
		else if (sh_q[1] == sh_q[2])
			level_q <= sh_q[2];
	end

	assign sif.level = level_q;
endmodule
`default_nettype wire

// [logic/lbh_arbiter.sv]
// Local-bus hold arbiter and bus-cycle sequencer: owns status, strobe and enables.
// Assumes internal requesters hold their request until started; one clock domain.
// Contract
// - On takeover request, finish current cycle, then acknowledge and float status, address, data.
// - While released, float selects, transceiver, strobes, byte enables; pull-ups keep them idle.
// - While released, address latch strobe floats and is held low.
// - Master drops request when done; device drops acknowledge and takes the bus back.
// - If device needs bus while released, it drops acknowledge while request remains; here only a pending refresh does so.
// - Refresh outranks takeover; takeover outranks DMA and processor cycles.
// - Takeover latency may reach four bus cycles, sixteen clocks, plus waits.
// - Never release the bus inside a locked transfer sequence.
// - Read strobe marks memory or I/O read cycles.
// - Read strobe never asserted before data lines are three-stated.
// - Read strobe floats, pulled inactive, during release and reset.
// - Status lines encode the kind of bus cycle in progress.
// - Status top bit alone tells memory from I/O.
// - Status middle bit alone tells transmit from receive.
// - Status codes: reserved, IO rd, IO wr, halt, fetch, mem rd, mem wr, passive.
`timescale 1ns/1ps
`default_nettype none
module lbh_arbiter
	import lbh_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       bus_takeover_request,
	output logic            bus_release_ack,
	input  wire logic       refresh_req,
	output logic            refresh_start,
	input  wire logic       cyc_req,
	input  wire logic [2:0] cyc_kind,
	input  wire logic       cyc_lock,
	input  wire logic       cyc_ready,
	output logic            cyc_start,
	output logic [2:0]      cycle_status_lines,
	output logic            status_oe,
	output logic            addr_oe,
	output logic            ad_oe,
	output logic            ctl_oe,
	output logic            read_strobe_n,
	output logic            read_strobe_oe,
	output logic            address_latch_strobe,
	output logic            address_latch_oe
);
	lbh_sync_if sif ();
	lbh_state_e state_q;
	lbh_state_e state_d;
	logic       hold_lvl;
	logic [2:0] kind_q;
	logic       lock_q;
	logic       ack_q;
	logic       own_q;
	logic       ad_oe_q;
	logic       rd_n_q;
	logic       ale_q;
	logic [2:0] status_q;
	logic       grant_hold;

	assign sif.raw = bus_takeover_request;

	lbh_sync u_sync
	(
		.mclk (mclk),
		.rst  (rst),
		.sif  (sif)
	);

	assign hold_lvl = sif.level;

	// Refresh first, then takeover, then other cycles; never inside a lock
	assign grant_hold    = hold_lvl && !refresh_req && !lock_q;
	assign refresh_start = (state_q == LBH_IDLE) && refresh_req;
	assign cyc_start     = (state_q == LBH_IDLE) && !refresh_req && !grant_hold && cyc_req;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			LBH_IDLE:
			begin
				if (refresh_req || (!grant_hold && cyc_req))
					state_d = LBH_T1;
				else if (grant_hold)
					state_d = LBH_HELD;
			end
			LBH_T1:
				state_d = LBH_T2;
			LBH_T2:
				state_d = LBH_T3;
			LBH_T3:
			begin
				// Wait states stretch T3 and so the hold latency
				if (cyc_ready)
					state_d = LBH_T4;
			end
			LBH_T4:
				state_d = LBH_IDLE;
			LBH_HELD:
			begin
				if (!hold_lvl)
					state_d = LBH_IDLE;
				else if (refresh_req)
					state_d = LBH_RECLAIM;
			end
			LBH_RECLAIM:
			begin
				// Relies on the master giving up once the acknowledge is gone
				if (!hold_lvl)
					state_d = LBH_IDLE;
			end
			default:
				state_d = LBH_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state_q <= LBH_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			kind_q <= LBH_ST_PASV;
			lock_q <= LBH_LOCK_RST;
		end
		else if (refresh_start)
			kind_q <= LBH_REFRESH_KIND;
		else if (cyc_start)
		begin
			kind_q <= cyc_kind;
			lock_q <= cyc_lock;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			ack_q <= LBH_ACK_RST;
		else
			ack_q <= (state_d == LBH_HELD);
	end

	// Drivers float in reset and whenever the bus is not ours
	always_ff @(posedge mclk)
	begin
		if (rst)
			own_q <= 1'b0;
		else
			own_q <= (state_d != LBH_HELD) && (state_d != LBH_RECLAIM);
	end

	// Data lines carry the address in T1; read data phase leaves them floating
	always_ff @(posedge mclk)
	begin
		if (rst)
			ad_oe_q <= 1'b0;
		else if (state_d == LBH_T1)
			ad_oe_q <= 1'b1;
		else if (state_d == LBH_HELD || state_d == LBH_RECLAIM)
			ad_oe_q <= 1'b0;
		else if (state_d == LBH_T2)
			ad_oe_q <= !lbh_is_read(kind_q);
	end

	// Strobe starts in T3, one clock after the data lines let go
	always_ff @(posedge mclk)
	begin
		if (rst)
			rd_n_q <= LBH_RD_N_RST;
		else
			rd_n_q <= !(lbh_is_read(kind_q) && (state_d == LBH_T3));
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			ale_q <= 1'b0;
		else
			ale_q <= (state_d == LBH_T1);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			status_q <= LBH_ST_PASV;
		else if (state_d == LBH_T1 || state_d == LBH_T2 || state_d == LBH_T3)
			status_q <= (state_q == LBH_IDLE) ? (refresh_start ? LBH_REFRESH_KIND : cyc_kind)
				: kind_q;
		else
			status_q <= LBH_ST_PASV;
	end

	assign bus_release_ack      = ack_q;
	assign cycle_status_lines   = status_q;
	assign status_oe            = own_q;
	assign addr_oe              = own_q;
	assign ad_oe                = ad_oe_q && own_q;
	assign ctl_oe               = own_q;
	assign read_strobe_n        = rd_n_q;
	assign read_strobe_oe       = own_q;
	assign address_latch_strobe = ale_q && own_q;
	assign address_latch_oe     = own_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_hold_seen;
		(state_q == LBH_IDLE) && grant_hold;
	endsequence

	sequence s_bus_released;
		bus_release_ack && !status_oe && !addr_oe && !ad_oe;
	endsequence

	a_ack_floats: assert property (bus_release_ack |-> !status_oe && !addr_oe && !ad_oe)
		else $error("bus driven while released");
	a_ctl_float: assert property (bus_release_ack |-> !ctl_oe && !read_strobe_oe)
		else $error("control pins driven while released");
	a_ale_low: assert property (bus_release_ack |-> !address_latch_oe && !address_latch_strobe)
		else $error("latch strobe not floated low");
	a_hold_end: assert property ((state_q == LBH_HELD) && !hold_lvl |=> !bus_release_ack ##1 own_q)
		else $error("bus not resumed after request dropped");
	a_reclaim_ack: assert property ((state_q == LBH_HELD) && hold_lvl && refresh_req |=> !bus_release_ack && hold_lvl)
		else $error("acknowledge kept while refresh pending");
	a_refresh_first: assert property ((state_q == LBH_IDLE) && refresh_req |=> state_q == LBH_T1 && !bus_release_ack)
		else $error("refresh lost priority");
	a_hold_grant: assert property (s_hold_seen |=> s_bus_released)
		else $error("hold not granted at cycle boundary");
	a_lock_kept: assert property (lock_q |-> !$rose(bus_release_ack))
		else $error("released inside locked sequence");
	a_read_strobe: assert property (!read_strobe_n |-> !ad_oe && lbh_is_read(cycle_status_lines))
		else $error("read strobe with data lines driven");
	a_status_dir: assert property (status_oe && !read_strobe_n |-> !cycle_status_lines[1])
		else $error("direction bit wrong during read");
	a_status_pasv: assert property ((state_q == LBH_T4) |-> cycle_status_lines == LBH_ST_PASV)
		else $error("status not passive at cycle end");
endmodule
`default_nettype wire

// [bench/lbh_master_model.sv]
// Partner model: an external master that borrows the local bus.
// Assumes mclk from the bench; acts on the rising edge so it never races falling-edge stimulus.
`timescale 1ns/1ps
`default_nettype none
module lbh_master_model
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic want,
	input  wire logic bus_release_ack,
	output logic      bus_takeover_request
);
	logic had_q;
	// Once the grant is taken away we stay off the bus until want drops
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			bus_takeover_request <= 1'b0;
			had_q                <= 1'b0;
		end
		else if (!want)
		begin
			bus_takeover_request <= 1'b0;
			had_q                <= 1'b0;
		end
		else if (bus_release_ack)
			had_q <= 1'b1;
		else if (had_q)
			bus_takeover_request <= 1'b0;
		else
			bus_takeover_request <= 1'b1;
	end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the hold arbiter with a bus master model.
// Assumes the arbiter synchronises the takeover pin itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lbh_pkg::*;
	logic        mclk, rst, want, req, ack, refresh_req, refresh_start;
	logic        cyc_req, cyc_lock, cyc_ready, cyc_start;
	logic [2:0]  cyc_kind, st;
	logic        status_oe, addr_oe, ad_oe, ctl_oe, rd_n, rd_oe, ale, ale_oe;
	int          errors, samples_checked, n, e;
	logic [31:0] rs;
	int          kq[$];

	lbh_arbiter i_lbh_arbiter (.mclk(mclk), .rst(rst), .bus_takeover_request(req),
		.bus_release_ack(ack), .refresh_req(refresh_req), .refresh_start(refresh_start),
		.cyc_req(cyc_req), .cyc_kind(cyc_kind), .cyc_lock(cyc_lock), .cyc_ready(cyc_ready),
		.cyc_start(cyc_start), .cycle_status_lines(st), .status_oe(status_oe),
		.addr_oe(addr_oe), .ad_oe(ad_oe), .ctl_oe(ctl_oe), .read_strobe_n(rd_n),
		.read_strobe_oe(rd_oe), .address_latch_strobe(ale), .address_latch_oe(ale_oe));
	lbh_master_model i_lbh_master_model (.mclk(mclk), .rst(rst), .want(want),
		.bus_release_ack(ack), .bus_takeover_request(req));

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_ack(input logic v, input int lim);
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (ack !== v && n < lim);
		chk("ack", v, ack);
	endtask

	// One bus cycle checked phase by phase against the queued kind
	task automatic run_cyc(input logic [2:0] k, input logic lk);
		logic rd;
		cyc_req = 1'b1;
		cyc_kind = k;
		cyc_lock = lk;
		kq.push_back(k);
		n = 0;
		// Look just after the falling edge, never at the edge that takes the request
		#1;
		while (cyc_start !== 1'b1 && n < 40)
		begin
			@(negedge mclk);
			#1;
			n++;
		end
		chk("cyc start", 8'h01, cyc_start);
		@(negedge mclk);
		cyc_req = 1'b0;
		e = kq.pop_front();
		rd = (e == LBH_ST_IORD) || (e == LBH_ST_FETCH) || (e == LBH_ST_MEMRD);
		chk("t1 status", e, st);
		chk("t1 ale ad_oe", 8'h03, {ale, ad_oe});
		@(negedge mclk);
		// Writes keep driving the data lines; only reads let go before the strobe
		chk("t2 ad_oe rd_n", {6'h00, !rd, 1'b1}, {ad_oe, rd_n});
		@(negedge mclk);
		chk("t3 rd_n", !rd, rd_n);
		@(negedge mclk);
		chk("t4 status rd_n", 8'h0f, {st, rd_n});
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		errors++;
		give_verdict();
	end

	initial
	begin
		rs = 32'hba00;
		rst = 1'b1;
		want = 1'b0;
		refresh_req = 1'b0;
		cyc_req = 1'b0;
		cyc_kind = 3'h0;
		cyc_lock = 1'b0;
		cyc_ready = 1'b1;
		errors = 0;
		samples_checked = 0;
		repeat (4) @(negedge mclk);
		chk("reset pins", 8'h87, {rd_n, rd_oe, ctl_oe, ad_oe, ale, st});
		rst = 1'b0;
		@(negedge mclk);
		for (int k = 1; k < 7; k++)
			run_cyc(k[2:0], 1'b0);
		repeat (6) run_cyc(3'(xs() % 6 + 1), 1'b0);
		$display("test cycle kinds done");
		// Request lands while a cycle runs: that cycle must finish first
		want = 1'b1;
		run_cyc(LBH_ST_MEMRD, 1'b0);
		wait_ack(1'b1, LBH_MAX_HOLD_CLKS + 8);
		chk("held bus oe", 8'h00, {status_oe, addr_oe, ad_oe});
		chk("held ctl oe", 8'h00, {ctl_oe, rd_oe});
		chk("held ale", 8'h00, {ale_oe, ale});
		want = 1'b0;
		wait_ack(1'b0, 8);
		chk("resume oe", 8'h03, {ctl_oe, status_oe});
		$display("test hold done");
		want = 1'b1;
		wait_ack(1'b1, 12);
		refresh_req = 1'b1;
		wait_ack(1'b0, 4);
		chk("req at reclaim", 8'h01, req);
		n = 0;
		#1;
		while (refresh_start !== 1'b1 && n < 20)
		begin
			@(negedge mclk);
			#1;
			n++;
		end
		chk("refresh start", 8'h01, refresh_start);
		@(negedge mclk);
		refresh_req = 1'b0;
		chk("refresh status", LBH_REFRESH_KIND, st);
		want = 1'b0;
		$display("test reclaim done");
		run_cyc(LBH_ST_MEMWR, 1'b1);
		want = 1'b1;
		repeat (12)
		begin
			@(negedge mclk);
			chk("locked ack", 8'h00, ack);
		end
		run_cyc(LBH_ST_FETCH, 1'b0);
		wait_ack(1'b1, LBH_MAX_HOLD_CLKS + 8);
		want = 1'b0;
		wait_ack(1'b0, 8);
		$display("test lock done");
		give_verdict();
	end
endmodule
`default_nettype wire
